// file: core/lagl_gate.sv
// locality gate over the register set, with the strapped legacy index/data port
//
// Behaviour
// [RULE1] owner change during execution aborts the command
// [RULE2] status register served only to the owner
// [RULE3] command/data port served only to the owner
// [RULE4] irq enable, vector, config: owner-only writes
// [RULE5] irq status readable always, owner write clears
// [RULE6] capability register read-only, readable everywhere
// [RULE7] access registers usable from any locality
// [RULE8] measure begin accepted at owner 4 or none
// [RULE9] measure data accepted only at owner 4
// [RULE10] measure finish at owner 4 releases ownership
// [RULE11] platform confines locality 4 to dynamic hardware
// [RULE12] strap input picks one of two legacy ranges
// [RULE13] strap high lower range, low higher range
// [RULE14] index at base, data at base plus one
// [RULE15] legacy cycles served only while nobody owns
// [RULE16] legacy active, locality switch causes an abort
// [RULE17] request and seize functions are implemented
// [RULE18] legacy registers shared by io and memory
// [RULE19] extension bytes widen legacy registers to 16
// [RULE20] unlisted legacy offsets alias by dropping bits
// [RULE21] legacy acts as locality 0 for measurements
// [RULE22] locality taken from address upper nibble
// [RULE23] highest requesting locality wins on release
// [RULE24] owner register resets to none, gates accesses
`include "lagl_map.svh"
module lagl_gate #(
	parameter int NLOC = `LAGL_NLOC
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic BASE_RANGE_STRAP,
	input wire logic LOC_CYC,
	input wire logic IO_CYC,
	input wire logic WR,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic CMD_DONE,
	output logic [7:0] RDATA,
	output logic ACK,
	output logic ABORT,
	output logic CMD_BUSY,
	output logic [7:0] CMD_BYTE,
	output logic CMD_BYTE_VLD,
	output logic MEAS_BEGIN,
	output logic MEAS_BYTE_VLD,
	output logic MEAS_FINISH,
	output logic [4:0] LOCALITY_ONEHOT_CODE
);
	import lagl_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	logic owner_flag_q;
	logic owner_flag_d;
	lagl_loc_t owner_q;
	lagl_loc_t owner_d;
	logic [NLOC-1:0] req_q;
	logic [NLOC-1:0] req_d;
	logic [NLOC-1:0] seize_q;
	logic [NLOC-1:0] seize_d;
	logic [7:0] irq_en_q;
	logic [7:0] irq_vec_q;
	logic [7:0] irq_sts_q;
	logic [7:0] cfg_q;
	logic [15:0] leg_idx_q;
	logic [15:0] leg_dat_q;
	logic [15:0] io_base_q;
	logic strap_seen_q;
	logic legacy_mode_q;
	lagl_exec_t exec_q;

	// ************************************************************
	// decode
	// ************************************************************
	// offset within a locality page; legacy window drops the two low bits
	function automatic logic [11:0] lagl_align(input logic [11:0] off);
		lagl_align = {off[11:2], 2'b00};
	endfunction : lagl_align

	function automatic logic lagl_hit(input logic [11:0] off, input logic [11:0] reg_off);
		lagl_hit = (lagl_align(off) == reg_off);
	endfunction : lagl_hit

	wire [2:0] loc = ADDR[14:12]; // [RULE22]
	wire loc_ok = LOC_CYC && !ADDR[15] && (loc < 3'd5);
	wire [11:0] off = ADDR[11:0];
	wire is_owner = owner_flag_q && (owner_q == loc); // [RULE24]
	wire no_owner = !owner_flag_q;
	wire own4 = owner_flag_q && (owner_q == 3'd4);
	wire hit_acc = loc_ok && (off == `LAGL_OFF_ACCESS);
	wire hit_ien = loc_ok && lagl_hit(off, `LAGL_OFF_IRQ_EN);
	wire hit_ivc = loc_ok && (off == `LAGL_OFF_IRQ_VEC);
	wire hit_ist = loc_ok && lagl_hit(off, `LAGL_OFF_IRQ_STS);
	wire hit_cap = loc_ok && lagl_hit(off, `LAGL_OFF_CAP);
	wire hit_sts = loc_ok && (off >= `LAGL_OFF_STS) && (off <= `LAGL_OFF_STS_END);
	wire hit_fifo = loc_ok && (loc != 3'd4) && lagl_hit(off, `LAGL_OFF_FIFO);
	wire hit_mend = loc_ok && (loc == 3'd4) && (off == `LAGL_OFF_MEAS_END);
	wire hit_mdat = loc_ok && (loc == 3'd4) && lagl_hit(off, `LAGL_OFF_MEAS_DATA);
	wire hit_mbeg = loc_ok && (loc == 3'd4) && (off == `LAGL_OFF_MEAS_BEGIN);
	// legacy window only exists in locality 0's page
	wire in_leg = loc_ok && (loc == 3'd0) && (off[11:4] == 8'hF8); // [RULE18]
	wire [11:0] leg_off = lagl_align(off); // [RULE20]
	wire hit_cfg = loc_ok && (off >= `LAGL_OFF_CFG_LO);
	// io range: index at base, data at base plus one
	wire io_idx = IO_CYC && (ADDR == io_base_q); // [RULE14]
	wire io_dat = IO_CYC && (ADDR == io_base_q + 16'h0001); // [RULE14]
	wire io_ok = no_owner; // [RULE15]

	// verdict for the current access
	wire serve_sts = is_owner; // [RULE2]
	wire serve_fifo = is_owner; // [RULE3]
	wire wr_cfg_ok = is_owner; // [RULE4]
	wire wr_ist_ok = is_owner; // [RULE5]
	wire mbeg_ok = own4 || no_owner; // [RULE8]
	wire mdat_ok = own4; // [RULE9]
	wire mend_ok = own4; // [RULE10]
	lagl_verdict_t verdict;
	assign verdict = (hit_sts && !serve_sts) || (hit_fifo && !serve_fifo) ? LAGL_FF_ANS :
		(hit_mbeg || hit_mdat || hit_mend) ? LAGL_ACCEPT : LAGL_SERVE;

	// access register view for one locality
	function automatic logic [7:0] lagl_acc_view(input lagl_loc_t l, input logic fl,
		input lagl_loc_t ow, input logic [NLOC-1:0] rq, input logic [NLOC-1:0] sz);
		logic [7:0] v;
		v = 8'h00;
		v[`LAGL_ACC_VALID_BIT] = 1'b1;
		v[`LAGL_ACC_ACTIVE_BIT] = fl && (ow == l);
		v[`LAGL_ACC_SEIZE_BIT] = sz[l];
		v[`LAGL_ACC_PEND_BIT] = |(rq & ~(NLOC'(1) << l));
		v[`LAGL_ACC_REQ_BIT] = rq[l];
		lagl_acc_view = v;
	endfunction : lagl_acc_view

	// ************************************************************
	// read data mux
	// ************************************************************
	logic [7:0] rd_mux;
	wire [7:0] sts_val = {1'b0, (exec_q == LAGL_IDLE), (exec_q == LAGL_EXEC), 5'h00};
	assign rd_mux =
		(io_idx && io_ok) ? leg_idx_q[7:0] :
		(io_dat && io_ok) ? leg_dat_q[7:0] :
		hit_acc ? lagl_acc_view(loc, owner_flag_q, owner_q, req_q, seize_q) : // [RULE7]
		hit_ien ? (off[1:0] == 2'b00 ? irq_en_q : 8'h00) : // [RULE4]
		hit_ivc ? irq_vec_q : // [RULE4]
		hit_ist ? (off[1:0] == 2'b00 ? irq_sts_q : 8'h00) : // [RULE5]
		hit_cap ? (off[1:0] == 2'b00 ? `LAGL_CAP_VALUE : 8'h00) : // [RULE6]
		(verdict == LAGL_FF_ANS) ? `LAGL_FF :
		hit_sts ? (off[1:0] == 2'b00 ? sts_val : 8'h00) :
		hit_fifo ? CMD_BYTE :
		(hit_mbeg || hit_mdat || hit_mend) ? `LAGL_FF : // [RULE8] [RULE9] [RULE10]
		(in_leg && leg_off == `LAGL_OFF_LEG_IDX) ? leg_idx_q[7:0] :
		(in_leg && leg_off == `LAGL_OFF_LEG_IDX_X) ? leg_idx_q[15:8] : // [RULE19]
		(in_leg && leg_off == `LAGL_OFF_LEG_DAT) ? leg_dat_q[7:0] :
		(in_leg && leg_off == `LAGL_OFF_LEG_DAT_X) ? leg_dat_q[15:8] : // [RULE19]
		hit_cfg ? cfg_q : 8'h00;

	// ************************************************************
	// ownership arbitration
	// ************************************************************
	// highest requesting locality; a seize beats plain requests
	function automatic lagl_loc_t lagl_top(input logic [NLOC-1:0] v);
		lagl_loc_t t;
		t = 3'd0;
		for (int i = 0; i < NLOC; i++) begin
			if (v[i]) begin
				t = 3'(i);
			end
		end
		lagl_top = t;
	endfunction : lagl_top

	wire acc_wr = WR && hit_acc;
	wire wr_req = acc_wr && WDATA[`LAGL_ACC_REQ_BIT];
	wire wr_seize = acc_wr && WDATA[`LAGL_ACC_SEIZE_BIT] && owner_flag_q && (loc > owner_q);
	wire wr_release = acc_wr && WDATA[`LAGL_ACC_ACTIVE_BIT] && is_owner;
	wire meas_beg_go = WR && hit_mbeg && mbeg_ok;
	wire meas_end_go = WR && hit_mend && mend_ok;
	wire [NLOC-1:0] loc_bit = NLOC'(1) << loc;

	always_comb begin
		owner_flag_d = owner_flag_q;
		owner_d = owner_q;
		req_d = req_q;
		seize_d = seize_q;
		if (wr_req) begin
			req_d = req_q | loc_bit; // [RULE17]
		end
		if (wr_seize) begin
			owner_d = loc; // [RULE17]
			seize_d = seize_q | loc_bit;
			req_d = req_d & ~loc_bit;
		end else if (wr_release || meas_end_go) begin
			// release hands over to the highest pending requester
			if (|(req_d & ~loc_bit)) begin
				owner_d = lagl_top(req_d & ~loc_bit); // [RULE23]
				req_d = req_d & ~(NLOC'(1) << lagl_top(req_d & ~loc_bit));
			end else begin
				owner_flag_d = 1'b0; // [RULE10]
			end
			seize_d = '0;
		end else if (meas_beg_go && no_owner) begin
			owner_flag_d = 1'b1; // [RULE8]
			owner_d = 3'd4;
		end else if (no_owner && |req_q) begin
			owner_flag_d = 1'b1; // [RULE23]
			owner_d = lagl_top(req_q);
			req_d = req_q & ~(NLOC'(1) << lagl_top(req_q));
		end
	end

	wire owner_changed = (owner_flag_d != owner_flag_q) || (owner_d != owner_q);
	// switching away from legacy use to any locality is an abort
	wire leg_abort = legacy_mode_q && owner_flag_d; // [RULE16]
	wire exec_abort = (exec_q == LAGL_EXEC) && owner_changed; // [RULE1]

	// ************************************************************
	// registers
	// ************************************************************
	// owner state resets to free; software may rely on that
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			owner_flag_q <= 1'b0; // [RULE24]
			owner_q <= 3'd0;
			req_q <= '0;
			seize_q <= '0;
		end else begin
			owner_flag_q <= owner_flag_d;
			owner_q <= owner_d;
			req_q <= req_d;
			seize_q <= seize_d;
		end
	end

	// strap caught once after reset release, not under reset
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			strap_seen_q <= 1'b0;
			io_base_q <= `LAGL_IO_LOW_BASE;
		end else if (!strap_seen_q) begin
			strap_seen_q <= 1'b1;
			io_base_q <= BASE_RANGE_STRAP ? `LAGL_IO_LOW_BASE : `LAGL_IO_HIGH_BASE; // [RULE12] [RULE13]
		end
	end

	// config group writes are owner-only
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			irq_en_q <= 8'h00;
			irq_vec_q <= 8'h00;
			cfg_q <= 8'h00;
		end else if (WR && wr_cfg_ok) begin
			if (hit_ien && off[1:0] == 2'b00) irq_en_q <= WDATA; // [RULE4]
			if (hit_ivc) irq_vec_q <= WDATA; // [RULE4]
			if (hit_cfg) cfg_q <= WDATA; // [RULE4]
		end
	end

	// interrupt status: command completion sets, owner write-one clears; set wins
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			irq_sts_q <= 8'h00;
		end else begin
			irq_sts_q <= (irq_sts_q & ~((WR && hit_ist && wr_ist_ok && off[1:0] == 2'b00) ?
				WDATA : 8'h00)) | {7'h00, CMD_DONE && exec_q == LAGL_EXEC}; // [RULE5]
		end
	end

	// one physical register per legacy name, reached by io or by memory
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			leg_idx_q <= 16'h0000;
			leg_dat_q <= 16'h0000;
		end else if (WR) begin
			if (io_idx && io_ok) leg_idx_q[7:0] <= WDATA; // [RULE15] [RULE18]
			if (io_dat && io_ok) leg_dat_q[7:0] <= WDATA; // [RULE15] [RULE18]
			if (in_leg && leg_off == `LAGL_OFF_LEG_IDX) leg_idx_q[7:0] <= WDATA;
			if (in_leg && leg_off == `LAGL_OFF_LEG_IDX_X) leg_idx_q[15:8] <= WDATA; // [RULE19]
			if (in_leg && leg_off == `LAGL_OFF_LEG_DAT) leg_dat_q[7:0] <= WDATA;
			if (in_leg && leg_off == `LAGL_OFF_LEG_DAT_X) leg_dat_q[15:8] <= WDATA; // [RULE19]
		end
	end

	// legacy mode is entered by an accepted io cycle and left once anyone owns
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			legacy_mode_q <= 1'b0;
		end else if (owner_flag_d) begin
			legacy_mode_q <= 1'b0;
		end else if ((io_idx || io_dat) && io_ok) begin
			legacy_mode_q <= 1'b1;
		end
	end

	// command execution: go bit from the owner starts, done or abort ends
	wire go_wr = WR && hit_sts && serve_sts && off[1:0] == 2'b00 && WDATA[`LAGL_STS_GO_BIT];
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			exec_q <= LAGL_IDLE;
		end else begin
			case (exec_q)
				LAGL_IDLE: begin
					if (go_wr && !owner_changed) exec_q <= LAGL_EXEC;
				end
				LAGL_EXEC: begin
					if (exec_abort || CMD_DONE) exec_q <= LAGL_IDLE; // [RULE1]
				end
				default: begin
					exec_q <= LAGL_IDLE;
				end
			endcase
		end
	end

	// outputs are all registered; answers appear one clock after the cycle
	wire any_cyc = LOC_CYC || IO_CYC;
	wire io_refused = IO_CYC && (io_idx || io_dat) && !io_ok; // [RULE15]
	wire [4:0] onehot = (IO_CYC || loc == 3'd0) ? 5'h01 : 5'(5'h01 << loc); // [RULE21]
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= 8'h00;
			ACK <= 1'b0;
			ABORT <= 1'b0;
			CMD_BUSY <= 1'b0;
			CMD_BYTE <= 8'h00;
			CMD_BYTE_VLD <= 1'b0;
			MEAS_BEGIN <= 1'b0;
			MEAS_BYTE_VLD <= 1'b0;
			MEAS_FINISH <= 1'b0;
			LOCALITY_ONEHOT_CODE <= 5'h00;
		end else begin
			RDATA <= (any_cyc && !WR) ? rd_mux : 8'h00;
			ACK <= (LOC_CYC && loc_ok) || ((io_idx || io_dat) && io_ok);
			ABORT <= exec_abort || leg_abort || io_refused; // [RULE1] [RULE16]
			CMD_BUSY <= (exec_q == LAGL_EXEC) && !exec_abort;
			CMD_BYTE_VLD <= WR && hit_fifo && serve_fifo; // [RULE3]
			if (WR && hit_fifo && serve_fifo) CMD_BYTE <= WDATA;
			MEAS_BEGIN <= meas_beg_go; // [RULE8]
			MEAS_BYTE_VLD <= WR && hit_mdat && mdat_ok; // [RULE9]
			MEAS_FINISH <= meas_end_go; // [RULE10]
			if (any_cyc) LOCALITY_ONEHOT_CODE <= onehot;
		end
	end
endmodule : lagl_gate

// file: shared/lagl_map.svh
// register offsets, reset values and codes for the locality access gate
`ifndef LAGL_MAP_SVH
`define LAGL_MAP_SVH
`define LAGL_OFF_ACCESS 12'h000
`define LAGL_OFF_IRQ_EN 12'h008
`define LAGL_OFF_IRQ_VEC 12'h00C
`define LAGL_OFF_IRQ_STS 12'h010
`define LAGL_OFF_CAP 12'h014
`define LAGL_OFF_STS 12'h018
`define LAGL_OFF_STS_END 12'h01A
`define LAGL_OFF_FIFO 12'h024
`define LAGL_OFF_MEAS_END 12'h020
`define LAGL_OFF_MEAS_DATA 12'h024
`define LAGL_OFF_MEAS_BEGIN 12'h028
`define LAGL_OFF_LEG_IDX 12'hF80
`define LAGL_OFF_LEG_IDX_X 12'hF84
`define LAGL_OFF_LEG_DAT 12'hF88
`define LAGL_OFF_LEG_DAT_X 12'hF8C
`define LAGL_OFF_CFG_LO 12'hF90
`define LAGL_IO_LOW_BASE 16'h002E
`define LAGL_IO_HIGH_BASE 16'h004E
`define LAGL_FF 8'hFF
`define LAGL_CAP_VALUE 8'h15
`define LAGL_ACC_VALID_BIT 7
`define LAGL_ACC_ACTIVE_BIT 5
`define LAGL_ACC_SEIZE_BIT 3
`define LAGL_ACC_PEND_BIT 2
`define LAGL_ACC_REQ_BIT 1
`define LAGL_STS_CMD_READY_BIT 6
`define LAGL_STS_GO_BIT 5
`define LAGL_NLOC 5
`endif

// file: shared/lagl_pkg.sv
// types shared by the locality access gate
package lagl_pkg;
	typedef logic [2:0] lagl_loc_t;
	typedef enum logic [1:0] {
		LAGL_SERVE,
		LAGL_FF_ANS,
		LAGL_IGNORE,
		LAGL_ACCEPT
	} lagl_verdict_t;
	typedef enum {
		LAGL_IDLE,
		LAGL_EXEC
	} lagl_exec_t;
endpackage : lagl_pkg

// file: test/lagl_gate_chk.sv
// concurrent checks on the locality gate ports
`include "lagl_map.svh"
module lagl_gate_chk (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic LOC_CYC,
	input wire logic IO_CYC,
	input wire logic WR,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic [7:0] RDATA,
	input wire logic ACK,
	input wire logic ABORT,
	input wire logic [7:0] CMD_BYTE,
	input wire logic CMD_BYTE_VLD,
	input wire logic MEAS_BEGIN,
	input wire logic MEAS_BYTE_VLD,
	input wire logic MEAS_FINISH,
	input wire logic [4:0] LOCALITY_ONEHOT_CODE
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// cycle decode helpers
	// ****
	wire logic rd_cyc = LOC_CYC && !WR;
	wire logic wr_cyc = LOC_CYC && WR;
	wire logic [2:0] loc_n = ADDR[14:12];
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// answers only ever follow a strobe
	property p_ack_cause;
		ACK |-> $past(LOC_CYC || IO_CYC);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without cycle");
	property p_loc_code;
		LOC_CYC && ADDR[15:12] <= 4'h4 |=> ACK && LOCALITY_ONEHOT_CODE == 5'h01 << $past(loc_n);
	endproperty
	a_loc_code: assert property (p_loc_code) else $error("locality code wrong");
	property p_io_code;
		IO_CYC ##1 ACK |-> LOCALITY_ONEHOT_CODE == 5'h01;
	endproperty
	a_io_code: assert property (p_io_code) else $error("io code wrong");
	property p_io_excl;
		IO_CYC |=> !(ACK && ABORT);
	endproperty
	a_io_excl: assert property (p_io_excl) else $error("io served and refused");
	property p_meas_rd;
		rd_cyc && ADDR[15:12] == 4'h4 && ADDR[11:0] inside {12'h020, 12'h024, 12'h028}
			|=> RDATA == `LAGL_FF;
	endproperty
	a_meas_rd: assert property (p_meas_rd) else $error("measure read not FF");
	property p_cap;
		rd_cyc && ADDR[11:0] == 12'h014 && ADDR[15:12] <= 4'h4 |=> RDATA == `LAGL_CAP_VALUE;
	endproperty
	a_cap: assert property (p_cap) else $error("capability read wrong");
	property p_begin;
		MEAS_BEGIN |-> $past(wr_cyc) && $past(ADDR) == 16'h4028;
	endproperty
	a_begin: assert property (p_begin) else $error("begin without write");
	property p_finish;
		MEAS_FINISH |-> $past(wr_cyc) && $past(ADDR) == 16'h4020;
	endproperty
	a_finish: assert property (p_finish) else $error("finish without write");
	property p_mdata;
		MEAS_BYTE_VLD |-> $past(wr_cyc) && ($past(ADDR) >> 2) == 16'h1009;
	endproperty
	a_mdata: assert property (p_mdata) else $error("measure byte stray");
	// data port byte carries the written value, localities 0 to 3 only
	property p_cmd;
		CMD_BYTE_VLD |-> $past(wr_cyc) && ($past(ADDR) & 16'hCFFC) == 16'h0024
			&& CMD_BYTE == $past(WDATA);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command byte stray");
endmodule : lagl_gate_chk

// file: test/lagl_host.sv
// host chipset model issuing locality and legacy io cycles
module lagl_host (
	input wire logic clock,
	output logic loc_cyc,
	output logic io_cyc,
	output logic wr,
	output logic [15:0] addr,
	output logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		loc_cyc = 1'h0;
		io_cyc = 1'h0;
		wr = 1'h0;
		addr = 16'h0000;
		wdata = 8'h00;
	end
	// one byte per cycle; locality rides in the upper address nibble
	// locality 4 is issued only by scenarios standing in for trusted hardware
	// released wr, address and data are inverted so a stale value never looks valid; strobes drop to 0
	task automatic cyc(input logic io, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		io_cyc = io;
		loc_cyc = !io;
		wr = w;
		addr = a;
		wdata = d;
		@(negedge clock);
		io_cyc = 1'h0;
		loc_cyc = 1'h0;
		wr = !w;
		addr = ~a;
		wdata = ~d;
	endtask : cyc
endmodule : lagl_host

// file: test/tb_top.sv
// self-checking bench for the locality gate
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	`define CK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
		$display("BAD %s exp %h got %h", nm, e, g); end end
	logic clock = 1'h0;
	logic rst_n, strap, cmd_done, ack, abort, busy, cmd_v, mb, md, mf;
	wire logic loc_cyc, io_cyc, wr;
	wire logic [15:0] addr;
	wire logic [7:0] wdata;
	logic [7:0] rdata, cmd_byte;
	logic [4:0] code;
	int n_fail = 0;
	int n_tests = 0;
	int cyc_n = 0;
	// ****
	// clock, parts and watchdog
	// ****
	always #10 clock = ~clock;
	lagl_host lagl_host_i (.clock(clock), .loc_cyc(loc_cyc), .io_cyc(io_cyc), .wr(wr),
		.addr(addr), .wdata(wdata));
	lagl_gate lagl_gate_i (.CLOCK(clock), .RST_N(rst_n), .BASE_RANGE_STRAP(strap),
		.LOC_CYC(loc_cyc), .IO_CYC(io_cyc), .WR(wr), .ADDR(addr), .WDATA(wdata),
		.CMD_DONE(cmd_done), .RDATA(rdata), .ACK(ack), .ABORT(abort), .CMD_BUSY(busy),
		.CMD_BYTE(cmd_byte), .CMD_BYTE_VLD(cmd_v), .MEAS_BEGIN(mb), .MEAS_BYTE_VLD(md),
		.MEAS_FINISH(mf), .LOCALITY_ONEHOT_CODE(code));
	// a hang stops here at cycle 5000, well past the fewer than two hundred cycles the tests need
	always @(posedge clock) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			n_fail++;
			final_report;
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// bus shorthands
	task automatic lw(input logic [15:0] a, input logic [7:0] d);
		lagl_host_i.cyc(1'h0, 1'h1, a, d);
	endtask : lw
	task automatic lr(input logic [15:0] a);
		lagl_host_i.cyc(1'h0, 1'h0, a, 8'h00);
	endtask : lr
	task automatic iw(input logic [15:0] a, input logic [7:0] d);
		lagl_host_i.cyc(1'h1, 1'h1, a, d);
	endtask : iw
	task automatic ir(input logic [15:0] a);
		lagl_host_i.cyc(1'h1, 1'h0, a, 8'h00);
	endtask : ir
	// abort may land a cycle after the write that moves the owner, so look over a short span
	task automatic watch(output logic s);
		s = abort;
		repeat (3) begin
			@(negedge clock);
			s = s | abort;
		end
	endtask : watch
	// ****
	// scenarios
	// ****
	task automatic t_free;
		lr(16'h2014);
		lw(16'h3014, 8'h00);
		lr(16'h3014);
		`CK("cap", 8'h15, rdata)
		lr(16'h0018);
		`CK("sts", 8'hFF, rdata)
		lr(16'h1024);
		`CK("fifo", 8'hFF, rdata)
		lr(16'h4024);
		`CK("mdata", 8'hFF, rdata)
		iw(16'h002E, 8'hA5);
		iw(16'h002F, 8'h3C);
		ir(16'h002E);
		`CK("io idx", 8'hA5, rdata)
		`CK("io code", 5'h01, code)
		lr(16'h0F80);
		`CK("mem idx", 8'hA5, rdata)
		lr(16'h0F88);
		`CK("mem dat", 8'h3C, rdata)
		ir(16'h004E);
		`CK("io miss", 1'h0, ack)
		$display("free test done");
	endtask : t_free
	task automatic t_own;
		logic s;
		ir(16'h002E);
		lw(16'h0000, 8'h02);
		watch(s);
		`CK("leg abort", 1'h1, s)
		lr(16'h0000);
		`CK("own", 8'h20, rdata & 8'h20)
		lr(16'h1000);
		`CK("l1 idle", 8'h00, rdata & 8'h20)
		lr(16'h1018);
		`CK("sts other", 8'hFF, rdata)
		lw(16'h1024, 8'h11);
		`CK("fifo other", 1'h0, cmd_v)
		lw(16'h0025, 8'h77);
		`CK("fifo own", 8'h77, cmd_byte)
		lw(16'h000C, 8'h05);
		lw(16'h100C, 8'h09);
		lr(16'h200C);
		`CK("vector", 8'h05, rdata)
		ir(16'h002E);
		`CK("io owned", 2'h1, {ack, abort})
		lw(16'h4028, 8'h00);
		`CK("begin l0", 1'h0, mb)
		lw(16'h4024, 8'h00);
		`CK("mdata l0", 1'h0, md)
		lw(16'h0F84, 8'h5A);
		lr(16'h0F86);
		`CK("idx ext", 8'h5A, rdata)
		$display("owner test done");
	endtask : t_own
	task automatic t_prio;
		lw(16'h1000, 8'h02);
		lw(16'h3000, 8'h02);
		lw(16'h0000, 8'h20);
		lr(16'h3000);
		`CK("l3 wins", 8'h20, rdata & 8'h20)
		lr(16'h1000);
		`CK("l1 waits", 8'h00, rdata & 8'h20)
		lw(16'h3000, 8'h20);
		lw(16'h1000, 8'h20);
		$display("priority test done");
	endtask : t_prio
	task automatic t_meas;
		lw(16'h4028, 8'h00);
		`CK("begin", 1'h1, mb)
		lr(16'h4000);
		`CK("l4 own", 8'h20, rdata & 8'h20)
		lw(16'h4025, 8'h5E);
		`CK("mdata", 1'h1, md)
		lr(16'h4028);
		`CK("begin rd", 8'hFF, rdata)
		lw(16'h4020, 8'h00);
		`CK("finish", 1'h1, mf)
		ir(16'h002E);
		`CK("io free", 1'h1, ack)
		$display("measure test done");
	endtask : t_meas
	task automatic t_exec;
		logic s;
		lw(16'h0000, 8'h02);
		lw(16'h0018, 8'h20);
		// busy is registered from the execute state, so it shows one clock after the go write
		@(negedge clock);
		`CK("busy", 1'h1, busy)
		@(negedge clock);
		cmd_done = 1'h1;
		@(negedge clock);
		cmd_done = 1'h0;
		lw(16'h1010, 8'h01);
		lr(16'h1010);
		`CK("irq set", 8'h01, rdata & 8'h01)
		lw(16'h0010, 8'h01);
		lr(16'h2010);
		`CK("irq clr", 8'h00, rdata & 8'h01)
		lw(16'h0018, 8'h20);
		lw(16'h2000, 8'h08);
		watch(s);
		`CK("seize abort", 1'h1, s)
		lr(16'h2000);
		`CK("seized", 8'h20, rdata & 8'h20)
		lw(16'h2000, 8'h20);
		$display("execute test done");
	endtask : t_exec
	task automatic t_strap;
		rst_n = 1'h0;
		strap = 1'h0;
		repeat (2) @(negedge clock);
		rst_n = 1'h1;
		repeat (2) @(negedge clock);
		iw(16'h004F, 8'h66);
		ir(16'h004F);
		`CK("high dat", 8'h66, rdata)
		ir(16'h002E);
		`CK("low off", 1'h0, ack)
		$display("strap test done");
	endtask : t_strap
	// main sequence
	initial begin
		rst_n = 1'h0;
		strap = 1'h1;
		cmd_done = 1'h0;
		repeat (16) @(negedge clock);
		rst_n = 1'h1;
		repeat (2) @(negedge clock);
		t_free;
		t_own;
		t_prio;
		t_meas;
		t_exec;
		t_strap;
		final_report;
	end
endmodule : tb_top
bind lagl_gate lagl_gate_chk lagl_gate_chk_i (.CLOCK, .RST_N, .LOC_CYC, .IO_CYC, .WR, .ADDR,
	.WDATA, .RDATA, .ACK, .ABORT, .CMD_BYTE, .CMD_BYTE_VLD, .MEAS_BEGIN, .MEAS_BYTE_VLD,
	.MEAS_FINISH, .LOCALITY_ONEHOT_CODE);
